// >>> core/refmon_regs.vh
`ifndef REFMON_REGS_VH
`define REFMON_REGS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses on the host register port)
// ----------------------------------------------------------------
`define OFS_REF_CFG       8'h0a
`define OFS_TIMER_CTL     8'h10
`define OFS_FMASK_01      8'h11
`define OFS_FMASK_23      8'h12
`define OFS_ABSENT_SEL    8'h13
`define OFS_ABSENT_CTL    8'h14
`define OFS_ACTIVE_REF    8'h15
`define OFS_LOOP0_MASK    8'h16
`define OFS_LOOP1_MASK    8'h17
`define OFS_STRAP         8'h18
`define OFS_NOM_BASE      8'h20
`define OFS_STAT_BASE     8'h30

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FLD_SOAK_LSB      0
`define FLD_QUAL_LSB      2
`define FLD_FORCE_HO_LSB  4
`define FLD_LOOP1_LSB     4
`define IND_SPC           0
`define IND_CFC           1
`define IND_SOAK          2
`define IND_ABSENT        3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_REF_CFG       8'h00
`define RST_TIMER_CTL     8'h06
`define RST_FMASK         8'hff
`define RST_ABSENT_SEL    8'h00
`define RST_ABSENT_CTL    8'h00
`define RST_ACTIVE_REF    8'h10
`define RST_LOOP_MASK     8'hff
`define RST_NOM           8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_FREQ_KHZ      50000
`define SOAK_10_MS        10
`define SOAK_50_MS        50
`define SOAK_2500_MS      2500
`define CFC_WINDOW_EDGES  1024
`define STRAP_SETTLE_CYC  2'h3

`endif

// >>> core/reference_input_monitor.v
`timescale 1ns/1ns
`include "refmon_regs.vh"
// ----------------------------------------------------------------
// per-reference checker
// ----------------------------------------------------------------
module ref_channel_check (
	input  wire        clk,
	input  wire        nrst,
	input  wire        ref_edge,
	input  wire        absent_in,
	input  wire [15:0] nom_period,
	input  wire [31:0] soak_cyc,
	input  wire [31:0] qual_cyc,
	output wire [3:0]  ind
);
	reg  [16:0] per_cnt_q;
	reg         seen_q;
	reg         spc_fail_q;
	reg  [9:0]  win_edges_q;
	reg  [26:0] win_sum_q;
	reg         cfc_fail_q;
	reg         disq_q;
	reg  [31:0] soak_cnt_q;
	wire [16:0] nom   = {1'b0, nom_period};
	wire [26:0] exp_w = {1'b0, nom_period, 10'h000};
	wire [26:0] diff  = (win_sum_q > exp_w) ? (win_sum_q - exp_w) : (exp_w - win_sum_q);
	wire [26:0] tol   = {11'h000, nom_period} + {17'h00000, nom_period[15:6]};
	wire        bad   = spc_fail_q | cfc_fail_q;
	// a zero nominal period disables both checks
	always @(posedge clk) begin
		if (!nrst) begin
			per_cnt_q  <= 17'h00000;
			seen_q     <= 1'b0;
			spc_fail_q <= 1'b0;
		end else if (nom_period == 16'h0000) begin
			seen_q     <= 1'b0;
			spc_fail_q <= 1'b0;
		end else if (ref_edge) begin
			per_cnt_q <= 17'h00001;
			seen_q    <= 1'b1;
			if (seen_q)
				spc_fail_q <= (per_cnt_q < (nom >> 1)) || (per_cnt_q > nom + (nom >> 1));
		end else if (seen_q) begin
			if (per_cnt_q != 17'h1ffff)
				per_cnt_q <= per_cnt_q + 17'h00001;
			if (per_cnt_q > (nom << 1))
				spc_fail_q <= 1'b1;
		end
	end
	// window of 1024 periods; tolerance nom*1.0156 sits just under 0.1 percent
	always @(posedge clk) begin
		if (!nrst || nom_period == 16'h0000) begin
			win_edges_q <= 10'h000;
			win_sum_q   <= 27'h0000000;
			cfc_fail_q  <= 1'b0;
		end else if (seen_q) begin
			if (ref_edge) begin
				win_edges_q <= win_edges_q + 10'h001;
				if (win_edges_q == 10'h3ff) begin
					cfc_fail_q <= (diff > tol);
					win_sum_q  <= 27'h0000001;
				end else begin
					win_sum_q <= win_sum_q + 27'h0000001;
				end
			end else if (win_sum_q != 27'h7ffffff) begin
				win_sum_q <= win_sum_q + 27'h0000001;
			end
		end
	end
	always @(posedge clk) begin
		if (!nrst) begin
			disq_q     <= 1'b0;
			soak_cnt_q <= 32'h00000000;
		end else if (!disq_q) begin
			if (!bad)
				soak_cnt_q <= 32'h00000000;
			else if (soak_cnt_q + 32'h00000001 >= soak_cyc) begin
				disq_q     <= 1'b1;
				soak_cnt_q <= 32'h00000000;
			end else
				soak_cnt_q <= soak_cnt_q + 32'h00000001;
		end else begin
			if (bad)
				soak_cnt_q <= 32'h00000000;
			else if (soak_cnt_q + 32'h00000001 >= qual_cyc) begin
				disq_q     <= 1'b0;
				soak_cnt_q <= 32'h00000000;
			end else
				soak_cnt_q <= soak_cnt_q + 32'h00000001;
		end
	end

	assign ind = {absent_in, disq_q, cfc_fail_q, spc_fail_q};
endmodule // ref_channel_check
// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module reference_input_monitor #(
	parameter [31:0] SOAK_10_CYC   = `SOAK_10_MS * `CLK_FREQ_KHZ,
	parameter [31:0] SOAK_50_CYC   = `SOAK_50_MS * `CLK_FREQ_KHZ,
	parameter [31:0] SOAK_2500_CYC = `SOAK_2500_MS * `CLK_FREQ_KHZ
) (
	input  wire       clk,
	input  wire       nrst,
	input  wire [3:0] ref_in,
	input  wire [3:0] gpio_in,
	input  wire [7:0] reg_addr,
	input  wire       reg_wr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	output reg  [3:0] ref_to_loop,
	output reg  [3:0] ref_valid,
	output reg  [3:0] ref_fail,
	output reg  [1:0] switch_request,
	output reg  [1:0] holdover_request,
	output reg  [1:0] mclk_sel
);
	reg  [7:0]  ref_cfg_q, timer_ctl_q, fmask01_q, fmask23_q;
	reg  [7:0]  absent_sel_q, absent_ctl_q, active_q, loop0_mask_q, loop1_mask_q;
	reg  [7:0]  nom_q [0:7];
	reg  [3:0]  ref_s1_q, ref_s2_q, ref_s3_q;
	reg  [3:0]  gpio_s1_q, gpio_s2_q;
	reg  [1:0]  strap_cnt_q;
	reg  [31:0] soak_cyc;
	reg  [31:0] qual_cyc;
	wire [3:0]  ref_edge = ref_s2_q & ~ref_s3_q;
	wire [15:0] ind_all;
	wire [15:0] fmask = {fmask23_q, fmask01_q};
	integer     i, j;
	// ------------------------------------------------------------
	// input synchronisers and master clock strap
	// ------------------------------------------------------------
	always @(posedge clk) begin
		ref_s1_q  <= ref_in;
		ref_s2_q  <= ref_s1_q;
		ref_s3_q  <= ref_s2_q;
		gpio_s1_q <= gpio_in;
		gpio_s2_q <= gpio_s1_q;
	end
	// strap is caught once the synchroniser holds post-reset samples
	always @(posedge clk) begin
		if (!nrst) begin
			strap_cnt_q <= 2'h0;
			mclk_sel    <= 2'h0;
		end else if (strap_cnt_q != `STRAP_SETTLE_CYC) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			mclk_sel    <= gpio_s2_q[1:0];
		end
	end
	// ------------------------------------------------------------
	// host registers
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (!nrst) begin
			ref_cfg_q    <= `RST_REF_CFG;
			timer_ctl_q  <= `RST_TIMER_CTL;
			fmask01_q    <= `RST_FMASK;
			fmask23_q    <= `RST_FMASK;
			absent_sel_q <= `RST_ABSENT_SEL;
			absent_ctl_q <= `RST_ABSENT_CTL;
			active_q     <= `RST_ACTIVE_REF;
			loop0_mask_q <= `RST_LOOP_MASK;
			loop1_mask_q <= `RST_LOOP_MASK;
			for (i = 0; i < 8; i = i + 1)
				nom_q[i] <= `RST_NOM;
		end else if (reg_wr) begin
			case (reg_addr)
				`OFS_REF_CFG:    ref_cfg_q    <= reg_wdata;
				`OFS_TIMER_CTL:  timer_ctl_q  <= reg_wdata;
				`OFS_FMASK_01:   fmask01_q    <= reg_wdata;
				`OFS_FMASK_23:   fmask23_q    <= reg_wdata;
				`OFS_ABSENT_SEL: absent_sel_q <= reg_wdata;
				`OFS_ABSENT_CTL: absent_ctl_q <= reg_wdata;
				`OFS_ACTIVE_REF: active_q     <= reg_wdata;
				`OFS_LOOP0_MASK: loop0_mask_q <= reg_wdata;
				`OFS_LOOP1_MASK: loop1_mask_q <= reg_wdata;
				default: begin
					if ({reg_addr[7:3], 3'h0} == `OFS_NOM_BASE)
						nom_q[reg_addr[2:0]] <= reg_wdata;
				end
			endcase
		end
	end
	always @(posedge clk) begin
		if (!nrst)
			reg_rdata <= 8'h00;
		else begin
			case (reg_addr)
				`OFS_REF_CFG:    reg_rdata <= ref_cfg_q;
				`OFS_TIMER_CTL:  reg_rdata <= timer_ctl_q;
				`OFS_FMASK_01:   reg_rdata <= fmask01_q;
				`OFS_FMASK_23:   reg_rdata <= fmask23_q;
				`OFS_ABSENT_SEL: reg_rdata <= absent_sel_q;
				`OFS_ABSENT_CTL: reg_rdata <= absent_ctl_q;
				`OFS_ACTIVE_REF: reg_rdata <= active_q;
				`OFS_LOOP0_MASK: reg_rdata <= loop0_mask_q;
				`OFS_LOOP1_MASK: reg_rdata <= loop1_mask_q;
				`OFS_STRAP:      reg_rdata <= {6'h00, mclk_sel};
				default: begin
					if ({reg_addr[7:3], 3'h0} == `OFS_NOM_BASE)
						reg_rdata <= nom_q[reg_addr[2:0]];
					else if ({reg_addr[7:2], 2'h0} == `OFS_STAT_BASE)
						reg_rdata <= {2'h0, ref_valid[reg_addr[1:0]], ref_fail[reg_addr[1:0]],
							ind_all[reg_addr[1:0]*4 +: 4]};
					else
						reg_rdata <= 8'h00;
				end
			endcase
		end
	end
	// ------------------------------------------------------------
	// soak and qualify times
	// ------------------------------------------------------------
	always @* begin
		case (timer_ctl_q[`FLD_SOAK_LSB +: 2])
			2'h0:    soak_cyc = 32'h00000001;
			2'h1:    soak_cyc = SOAK_10_CYC;
			2'h2:    soak_cyc = SOAK_50_CYC;
			default: soak_cyc = SOAK_2500_CYC;
		endcase
		case (timer_ctl_q[`FLD_QUAL_LSB +: 2])
			2'h0:    qual_cyc = soak_cyc << 1;
			2'h1:    qual_cyc = soak_cyc << 2;
			2'h2:    qual_cyc = soak_cyc << 4;
			default: qual_cyc = soak_cyc << 5;
		endcase
	end
	// ------------------------------------------------------------
	// per-reference monitors
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : chan
			wire absent = absent_ctl_q[g] & gpio_s2_q[absent_sel_q[2*g +: 2]];
			ref_channel_check u_chk (
				.clk        (clk),
				.nrst       (nrst),
				.ref_edge   (ref_edge[g]),
				.absent_in  (absent),
				.nom_period ({nom_q[2*g+1], nom_q[2*g]}),
				.soak_cyc   (soak_cyc),
				.qual_cyc   (qual_cyc),
				.ind        (ind_all[4*g +: 4])
			);
		end
	endgenerate
	// ------------------------------------------------------------
	// masked outputs and loop reference path
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (!nrst) begin
			ref_fail         <= 4'h0;
			ref_valid        <= 4'h0;
			ref_to_loop      <= 4'h0;
			switch_request   <= 2'h0;
			holdover_request <= 2'h0;
		end else begin
			for (j = 0; j < 4; j = j + 1) begin
				ref_fail[j]  <= |(ind_all[4*j +: 4] & fmask[4*j +: 4]);
				ref_valid[j] <= ~|(ind_all[4*j +: 3] & fmask[4*j +: 3]);
				// halving gives a 50 percent duty cycle at a rate the loop can take
				if (!ref_cfg_q[j])
					ref_to_loop[j] <= ref_s3_q[j];
				else if (ref_edge[j])
					ref_to_loop[j] <= ~ref_to_loop[j];
			end
			switch_request[0] <= |(ind_all[4*active_q[1:0] +: 4] & loop0_mask_q[3:0]);
			switch_request[1] <= |(ind_all[4*active_q[`FLD_LOOP1_LSB +: 2] +: 4] & loop1_mask_q[3:0]);
			// loop then runs from frequency stored while locked
			holdover_request[0] <= absent_ctl_q[`FLD_FORCE_HO_LSB] |
				|(ind_all[4*active_q[1:0] +: 4] & loop0_mask_q[7:4]);
			holdover_request[1] <= absent_ctl_q[`FLD_FORCE_HO_LSB + 1] |
				|(ind_all[4*active_q[`FLD_LOOP1_LSB +: 2] +: 4] & loop1_mask_q[7:4]);
		end
	end
endmodule // reference_input_monitor

// >>> testbench/refmon_checker.sv
`timescale 1ns/1ns
`include "refmon_regs.vh"
module refmon_checker (
	input wire       clk,
	input wire       nrst,
	input wire [3:0] ref_in,
	input wire [3:0] gpio_in,
	input wire [7:0] reg_addr,
	input wire       reg_wr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire [3:0] ref_to_loop,
	input wire [3:0] ref_valid,
	input wire [3:0] ref_fail,
	input wire [1:0] switch_request,
	input wire [1:0] holdover_request,
	input wire [1:0] mclk_sel
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	reg [2:0] cnt_q = 3'h0;
	reg [3:0] idle_q = 4'h0;
	reg       last_q = 1'b0;
	always @(posedge clk) begin
		if (!nrst)
			cnt_q <= 3'h0;
		else if (cnt_q != 3'h7)
			cnt_q <= cnt_q + 3'h1;
	end
	// cycles since ref1 last moved; the loop path must never move on its own
	always @(posedge clk) begin
		last_q <= ref_in[1];
		if (ref_in[1] != last_q)
			idle_q <= 4'h0;
		else if (idle_q != 4'hf)
			idle_q <= idle_q + 4'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_unmapped_read: assert property (reg_addr == 8'h05 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_cfg_readback: assert property (reg_wr && reg_addr == `OFS_TIMER_CTL ##1 !reg_wr
		&& reg_addr == `OFS_TIMER_CTL |=> (reg_rdata & 8'h0f) == ($past(reg_wdata, 2) & 8'h0f))
		else $error("timer control readback wrong");
	a_cfg_stable: assert property (cnt_q > 3'h2 && !reg_wr && !$past(reg_wr) && $stable(reg_addr)
		&& reg_addr == `OFS_TIMER_CTL |=> $stable(reg_rdata)) else $error("config readback moved");
	a_release_quiet: assert property ($rose(nrst) |-> ref_valid == 4'h0 && ref_fail == 4'h0
		&& switch_request == 2'h0 && holdover_request == 2'h0) else $error("outputs not clear after reset");
	a_strap_frozen: assert property (cnt_q >= 3'h6 |-> $stable(mclk_sel))
		else $error("strap select moved");
	a_loop_follows: assert property ($changed(ref_to_loop[1]) |-> idle_q < 4'h8)
		else $error("loop reference moved without input edge");
	a_force_holdover: assert property (reg_wr && reg_addr == `OFS_ABSENT_CTL && reg_wdata[5]
		|-> ##[1:3] holdover_request[1]) else $error("forced holdover missing");
	a_fault_mask: assert property (reg_wr && reg_addr == `OFS_FMASK_23 && reg_wdata[3:0] == 4'h0
		|-> ##[1:3] (!ref_fail[2] && ref_valid[2])) else $error("masked ref2 still failing");
	a_switch_mask: assert property (reg_wr && reg_addr == `OFS_LOOP0_MASK && reg_wdata[3:0] == 4'h0
		|-> ##[1:3] !switch_request[0]) else $error("masked switch request seen");
	c_switch: cover property (switch_request[0]);
	c_disq: cover property (!ref_valid[2]);
	c_absent: cover property (ref_fail[0]);
endmodule // refmon_checker

bind reference_input_monitor refmon_checker chk (.clk, .nrst, .ref_in, .gpio_in, .reg_addr, .reg_wr, .reg_wdata,
	.reg_rdata, .ref_to_loop, .ref_valid, .ref_fail, .switch_request, .holdover_request, .mclk_sel);

// >>> testbench/ref_phy.sv
`timescale 1ns/1ns
module ref_phy (
	input  wire [3:0] stop,
	input  wire [3:0] lvl,
	output reg  [3:0] ref_in,
	output wire [3:0] gpio_in
);
	integer k;
	assign gpio_in = lvl;
	// 21 master cycles a period, offset so edges never meet clk edges; a stopped clock stands still
	initial begin
		ref_in = 4'h0;
		#3;
		forever begin
			#210;
			for (k = 0; k < 4; k = k + 1)
				if (!stop[k]) ref_in[k] = ~ref_in[k];
		end
	end
endmodule // ref_phy

// >>> testbench/reference_input_monitor_tb_top.sv
`timescale 1ns/1ns
`include "refmon_regs.vh"
module reference_input_monitor_tb_top;
	reg        clk = 1'b0;
	reg        nrst = 1'b0;
	reg  [3:0] stop = 4'h0;
	reg  [3:0] lvl = 4'h2;
	reg  [7:0] reg_addr = 8'h00;
	reg        reg_wr = 1'b0;
	reg  [7:0] reg_wdata = 8'h00;
	reg        p = 1'b0;
	wire [3:0] ref_in, gpio_in, ref_to_loop, ref_valid, ref_fail;
	wire [7:0] reg_rdata;
	wire [1:0] sw_req, ho_req, mclk_sel;
	integer    n_mismatch = 0;
	integer    checked = 0;
	integer    i, n;
	initial forever #10 clk = ~clk;
	ref_phy phy (.stop(stop), .lvl(lvl), .ref_in(ref_in), .gpio_in(gpio_in));
	reference_input_monitor #(.SOAK_10_CYC(20), .SOAK_50_CYC(50), .SOAK_2500_CYC(100)) dut (
		.clk(clk), .nrst(nrst), .ref_in(ref_in), .gpio_in(gpio_in), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ref_to_loop(ref_to_loop), .ref_valid(ref_valid),
		.ref_fail(ref_fail), .switch_request(sw_req), .holdover_request(ho_req), .mclk_sel(mclk_sel));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("FAIL %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(negedge clk);
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(negedge clk);
			reg_addr = a;
			reg_wdata = d;
			reg_wr = 1'b1;
			@(negedge clk);
			reg_wr = 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] m, input [7:0] exp);
		begin
			@(negedge clk);
			reg_addr = a;
			@(negedge clk);
			chk(reg_rdata & m, exp);
		end
	endtask
	task end_of_test;
		begin
			if (n_mismatch == 0 && checked > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		begin
			cyc(6);
			chk({6'h00, mclk_sel}, 8'h02);
			lvl = 4'h0;
			cyc(4);
			chk({6'h00, mclk_sel}, 8'h02);
			rd(`OFS_REF_CFG, 8'hff, `RST_REF_CFG);
			rd(`OFS_TIMER_CTL, 8'hff, `RST_TIMER_CTL);
			rd(`OFS_FMASK_23, 8'hff, `RST_FMASK);
			rd(`OFS_ABSENT_CTL, 8'hff, `RST_ABSENT_CTL);
			rd(`OFS_ACTIVE_REF, 8'hff, `RST_ACTIVE_REF);
			rd(`OFS_LOOP1_MASK, 8'hff, `RST_LOOP_MASK);
			rd(8'h05, 8'hff, 8'h00);
		end
	endtask
	task t_good;
		begin
			for (i = 0; i < 4; i = i + 1)
				wr(`OFS_NOM_BASE + 8'(2 * i), 8'h15);
			wr(`OFS_TIMER_CTL, 8'h00);
			rd(`OFS_TIMER_CTL, 8'h0f, 8'h00);
			cyc(25000);
			chk({4'h0, ref_valid}, 8'h0f);
			chk({4'h0, ref_fail}, 8'h00);
			rd(`OFS_STAT_BASE, 8'h3f, 8'h20);
		end
	endtask
	// ref2 vanishes; it stays stopped for the rest of the run
	task t_stop;
		begin
			stop[2] = 1'b1;
			cyc(100);
			chk({ref_valid, ref_fail}, 8'hb4);
			rd(`OFS_STAT_BASE + 8'h02, 8'h35, 8'h15);
			chk({4'h0, sw_req, ho_req}, 8'h00);
			wr(`OFS_ACTIVE_REF, 8'h12);
			cyc(3);
			chk({4'h0, sw_req, ho_req}, 8'h05);
			wr(`OFS_LOOP0_MASK, 8'hf0);
			cyc(3);
			chk({4'h0, sw_req, ho_req}, 8'h01);
			wr(`OFS_FMASK_23, 8'hf0);
			cyc(3);
			chk({ref_valid, ref_fail}, 8'hf0);
		end
	endtask
	task t_absent;
		begin
			wr(`OFS_ABSENT_SEL, 8'h03);
			wr(`OFS_ABSENT_CTL, 8'h01);
			lvl[3] = 1'b1;
			cyc(8);
			chk({ref_valid, ref_fail}, 8'hf1);
			rd(`OFS_STAT_BASE, 8'h08, 8'h08);
			wr(`OFS_ABSENT_CTL, 8'h21);
			cyc(3);
			chk({6'h00, ho_req}, 8'h03);
			lvl[3] = 1'b0;
		end
	endtask
	// ref3 outage seen on loop1: period failure drives switch, soak disqualify drives holdover
	task t_requal;
		begin
			wr(`OFS_ABSENT_CTL, 8'h31);
			wr(`OFS_NOM_BASE + 8'h06, 8'h00);
			wr(`OFS_NOM_BASE + 8'h06, 8'h15);
			wr(`OFS_TIMER_CTL, 8'h01);
			wr(`OFS_ACTIVE_REF, 8'h32);
			wr(`OFS_LOOP1_MASK, 8'h41);
			wr(`OFS_ABSENT_CTL, 8'h00);
			cyc(3);
			chk({4'h0, sw_req, ho_req}, 8'h01);
			stop[3] = 1'b1;
			n = 32'h0;
			while (!sw_req[1] && n < 32'hc8) begin
				@(negedge clk);
				n = n + 1;
			end
			n = 32'h0;
			while (!ho_req[1] && n < 32'hc8) begin
				@(negedge clk);
				n = n + 1;
			end
			chk(n[7:0], 8'h14);
			chk({ref_valid, ref_fail}, 8'h78);
			stop[3] = 1'b0;
			n = 32'h0;
			while (sw_req[1] && n < 32'hc8) begin
				@(negedge clk);
				n = n + 1;
			end
			n = 32'h0;
			while (ho_req[1] && n < 32'hc8) begin
				@(negedge clk);
				n = n + 1;
			end
			chk(n[7:0], 8'h28);
		end
	endtask
	task t_div;
		begin
			wr(`OFS_REF_CFG, 8'h02);
			cyc(10);
			n = 0;
			repeat (2100) begin
				@(negedge clk);
				if (ref_to_loop[1] && !p) n = n + 1;
				p = ref_to_loop[1];
			end
			chk({7'h00, n >= 49 && n <= 51}, 8'h01);
		end
	endtask
	initial begin
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		t_reset;
		t_good;
		t_stop;
		t_absent;
		t_requal;
		t_div;
		end_of_test;
	end
	initial begin
		#1500000;
		n_mismatch = n_mismatch + 1;
		end_of_test;
	end
endmodule // reference_input_monitor_tb_top
